// ### common/gate_drive_map.svh
// Constants of the three-phase gate drive device and its controller.
//
// Behaviour
// - High command alone drives high gate.
// - Low command alone drives low gate.
// - Both or neither command gives both gates low.
// - Undriven commands read as high, inactive.
// - Controller keeps command pulses at least 500 ns.
// - Controller inserts its own dead time.
// - Enable low-pass filtered, about 2.5 us.
// - Commands act directly, without filtering.
// - Enable low: gates low, fault high.
// - Undriven enable reads as low.
// - After enable, resume on next falling command edge.
// - Hard protections force gates low, fault low.
// - On release fault clears first, then resume.
// - Gate supply undervoltage only signals fault.
// - Fault is open-drain, pulled up outside.
// - Overvoltage trips at 28 V, releases 25 V.
// - Main undervoltage 6.1/6.5 V, forces gates low, fault low, stops boost.
// - Logic undervoltage trips 3.8 V, releases 4.0 V.
// - Gate supply undervoltage 7.1 V, releases 7.5 V.
// - Thermal trip near 165 C, release 10 C lower.
// - Controller enables first, then toggles commands.
// - Controller turns low sides on first.
`ifndef GATE_DRIVE_MAP_SVH
`define GATE_DRIVE_MAP_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS        10
`define ENABLE_TAU_NS        2500
`define ENABLE_FILTER_CYCLES ((`ENABLE_TAU_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_PULSE_NS         500
`define MIN_PULSE_CYCLES     ((`MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EN_SETTLE_CYCLES     (2 * `ENABLE_FILTER_CYCLES)
`define PRECHARGE_NS         20000
`define PRECHARGE_CYCLES     ((`PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Protection thresholds, millivolts and degrees Celsius
// ----------------------------------------------------------------------------
`define OVP_TRIP_MV          16'h6D60
`define OVP_RELEASE_MV       16'h61A8
`define MAIN_UV_TRIP_MV      16'h17D4
`define MAIN_UV_RELEASE_MV   16'h1964
`define LOGIC_UV_TRIP_MV     16'h0ED8
`define LOGIC_UV_RELEASE_MV  16'h0FA0
`define GATE_UV_TRIP_MV      16'h1BBC
`define GATE_UV_RELEASE_MV   16'h1D4C
`define THERMAL_TRIP_C       8'hA5
`define THERMAL_HYST_C       8'h0A

// ----------------------------------------------------------------------------
// Controller registers
// ----------------------------------------------------------------------------
`define REG_CTRL             8'h00
`define REG_TARGET           8'h04
`define REG_DEAD             8'h08
`define REG_STATUS           8'h0C
`define CTRL_RUN_BIT         0
`define DEAD_RESET           8'h14

`endif

// ### common/gate_drive_pkg.sv
// Types shared by the gate drive device and its controller.
package gate_drive_pkg;

  typedef enum logic [1:0] {
    PH_OFF  = 2'h0,
    PH_HIGH = 2'h1,
    PH_LOW  = 2'h2
  } phase_cmd_t;

  typedef enum logic [1:0] {
    CTL_IDLE      = 2'h0,
    CTL_WAIT_EN   = 2'h1,
    CTL_PRECHARGE = 2'h3,
    CTL_RUN       = 2'h2
  } ctl_state_t;

  typedef struct packed {
    logic over_voltage;
    logic main_under;
    logic logic_under;
    logic gate_under;
    logic thermal;
  } prot_flags_t;

endpackage

// ### common/gate_drive_if.sv
// Pin level connection between the motor controller and the gate drive device.
`timescale 1ns/1ps
interface gate_drive_if;
  logic [2:0] high_side_cmd_n_out;
  logic [2:0] low_side_cmd_n_out;
  logic       cmd_oe;
  logic       enable_out;
  logic       enable_oe;
  logic       fault_out_n_out;
  logic       fault_out_n_oe;
  logic [2:0] high_side_cmd_n;
  logic [2:0] low_side_cmd_n;
  logic       enable;
  logic       fault_out_n;

  // Internal pull-ups on commands, pull-down on enable, outside pull-up on fault.
  assign high_side_cmd_n = cmd_oe ? high_side_cmd_n_out : 3'h7;
  assign low_side_cmd_n  = cmd_oe ? low_side_cmd_n_out : 3'h7;
  assign enable          = enable_oe ? enable_out : 1'b0;
  assign fault_out_n     = fault_out_n_oe ? fault_out_n_out : 1'b1;

  modport device (
    input  high_side_cmd_n,
    input  low_side_cmd_n,
    input  enable,
    output fault_out_n_out,
    output fault_out_n_oe
  );

  modport controller (
    output high_side_cmd_n_out,
    output low_side_cmd_n_out,
    output cmd_oe,
    output enable_out,
    output enable_oe,
    input  fault_out_n
  );
endinterface

// ### verilog/gate_drive_controller.sv
// Motor controller end: dead time, pulse width and startup order of the commands.
`timescale 1ns/1ps
`include "gate_drive_map.svh"
module gate_drive_controller (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  gate_drive_if.controller link,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata
);

  localparam logic [11:0] MIN_PULSE = 12'(`MIN_PULSE_CYCLES);
  localparam logic [11:0] EN_SETTLE = 12'(`EN_SETTLE_CYCLES);
  localparam logic [11:0] PRECHARGE = 12'(`PRECHARGE_CYCLES);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic                      run;
  logic [5:0]                target;
  logic [7:0]                dead_cycles;
  logic                      fault_meta;
  logic                      fault_sync_n;
  gate_drive_pkg::ctl_state_t state;
  logic [11:0]               state_cnt;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      run         <= 1'b0;
      target      <= 6'h00;
      dead_cycles <= `DEAD_RESET;
    end else if (clk_en && reg_write) begin
      if (reg_addr == `REG_CTRL) begin
        run <= reg_wdata[`CTRL_RUN_BIT];
      end else if (reg_addr == `REG_TARGET) begin
        target <= reg_wdata[5:0];
      end else if (reg_addr == `REG_DEAD) begin
        dead_cycles <= reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (!reg_read) begin
        reg_rdata <= 32'h0000_0000;
      end else if (reg_addr == `REG_CTRL) begin
        reg_rdata <= {31'h0, run};
      end else if (reg_addr == `REG_TARGET) begin
        reg_rdata <= {26'h0, target};
      end else if (reg_addr == `REG_DEAD) begin
        reg_rdata <= {24'h0, dead_cycles};
      end else if (reg_addr == `REG_STATUS) begin
        reg_rdata <= {29'h0, state, ~fault_sync_n};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fault_meta   <= 1'b1;
      fault_sync_n <= 1'b1;
    end else if (clk_en) begin
      fault_meta   <= link.fault_out_n;
      fault_sync_n <= fault_meta;
    end
  end

  // --------------------------------------------------------------------------
  // Startup sequence
  // --------------------------------------------------------------------------
  // Enable is raised and given time through the device filter before any
  // command moves, and the low sides lead so the boot capacitors charge.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state     <= gate_drive_pkg::CTL_IDLE;
      state_cnt <= 12'h000;
    end else if (clk_en) begin
      state_cnt <= state_cnt + 12'h001;
      if (!run) begin
        state     <= gate_drive_pkg::CTL_IDLE;
        state_cnt <= 12'h000;
      end else begin
        case (state)
          gate_drive_pkg::CTL_IDLE: begin
            state     <= gate_drive_pkg::CTL_WAIT_EN;
            state_cnt <= 12'h000;
          end
          gate_drive_pkg::CTL_WAIT_EN: begin
            if (state_cnt >= EN_SETTLE) begin
              state     <= gate_drive_pkg::CTL_PRECHARGE;
              state_cnt <= 12'h000;
            end
          end
          gate_drive_pkg::CTL_PRECHARGE: begin
            if (state_cnt >= PRECHARGE) begin
              state     <= gate_drive_pkg::CTL_RUN;
              state_cnt <= 12'h000;
            end
          end
          default: begin
            state_cnt <= 12'h000;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Per-phase command shaping
  // --------------------------------------------------------------------------
  gate_drive_pkg::phase_cmd_t phase_cur  [3];
  gate_drive_pkg::phase_cmd_t next_cur   [3];
  logic [11:0]                phase_cnt  [3];
  logic [11:0]                next_cnt   [3];
  gate_drive_pkg::phase_cmd_t want;
  logic [11:0]                off_hold;

  always_comb begin
    want     = gate_drive_pkg::PH_OFF;
    off_hold = (12'(dead_cycles) > MIN_PULSE) ? 12'(dead_cycles) : MIN_PULSE;
    for (int i = 0; i < 3; i++) begin
      next_cur[i] = phase_cur[i];
      next_cnt[i] = phase_cnt[i];
      if (state == gate_drive_pkg::CTL_RUN) begin
        want = gate_drive_pkg::phase_cmd_t'(target[2*i +: 2]);
      end else if (state == gate_drive_pkg::CTL_PRECHARGE) begin
        want = gate_drive_pkg::PH_LOW;
      end else begin
        want = gate_drive_pkg::PH_OFF;
      end
      if (want != gate_drive_pkg::PH_HIGH && want != gate_drive_pkg::PH_LOW) begin
        want = gate_drive_pkg::PH_OFF;
      end
      if (state == gate_drive_pkg::CTL_IDLE) begin
        next_cur[i] = gate_drive_pkg::PH_OFF;
        next_cnt[i] = 12'h000;
      end else if (phase_cnt[i] != 12'h000) begin
        next_cnt[i] = phase_cnt[i] - 12'h001;
      end else if (want != phase_cur[i]) begin
        if (phase_cur[i] != gate_drive_pkg::PH_OFF) begin
          // Every change passes through both-off for the dead time or the minimum pulse, whichever is longer.
          next_cur[i] = gate_drive_pkg::PH_OFF;
          next_cnt[i] = off_hold;
        end else begin
          next_cur[i] = want;
          next_cnt[i] = MIN_PULSE;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 3; i++) begin
        phase_cur[i] <= gate_drive_pkg::PH_OFF;
        phase_cnt[i] <= 12'h000;
      end
      link.high_side_cmd_n_out <= 3'h7;
      link.low_side_cmd_n_out  <= 3'h7;
      link.cmd_oe              <= 1'b0;
      link.enable_out          <= 1'b0;
      link.enable_oe           <= 1'b0;
    end else if (clk_en) begin
      for (int i = 0; i < 3; i++) begin
        phase_cur[i] <= next_cur[i];
        phase_cnt[i] <= next_cnt[i];
        link.high_side_cmd_n_out[i] <= (next_cur[i] != gate_drive_pkg::PH_HIGH);
        link.low_side_cmd_n_out[i]  <= (next_cur[i] != gate_drive_pkg::PH_LOW);
      end
      link.cmd_oe     <= (state != gate_drive_pkg::CTL_IDLE);
      link.enable_out <= run;
      link.enable_oe  <= run;
    end
  end

endmodule

// ### verilog/gate_drive_logic.sv
// Device end: gate decode, enable filter, protection monitors and fault output.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "gate_drive_map.svh"
module gate_drive_logic (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  gate_drive_if.device           link,
  input  wire logic [15:0]       main_supply_mv,
  input  wire logic [15:0]       logic_supply_mv,
  input  wire logic [2:0][15:0]  gate_drive_supply_mv,
  input  wire logic [7:0]        junction_temp_c,
  output logic      [2:0]        high_gate_drive,
  output logic      [2:0]        low_gate_drive,
  output logic                   charge_pump_boost_en,
  output logic                   oscillator_run,
  output gate_drive_pkg::prot_flags_t protection_flags
);

  localparam logic [8:0] FILTER_MAX   = 9'(`ENABLE_FILTER_CYCLES);
  localparam logic [7:0] HOT_TRIP     = `THERMAL_TRIP_C;
  localparam logic [7:0] HOT_RELEASE  = `THERMAL_TRIP_C - `THERMAL_HYST_C;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Comparator with hysteresis for a quantity that trips when it rises.
  function automatic logic trip_rising(input logic        active,
                                       input logic [15:0] value,
                                       input logic [15:0] trip,
                                       input logic [15:0] release_at);
    if (active) begin
      return value > release_at;
    end
    return value >= trip;
  endfunction

  // Comparator with hysteresis for a quantity that trips when it falls.
  function automatic logic trip_falling(input logic        active,
                                        input logic [15:0] value,
                                        input logic [15:0] trip,
                                        input logic [15:0] release_at);
    if (active) begin
      return value < release_at;
    end
    return value <= trip;
  endfunction

  // Gate pattern for one phase from its two active-low commands.
  function automatic logic [1:0] decode_phase(input logic hi_n, input logic lo_n);
    logic [1:0] gates;
    gates = 2'h0;
    if (!hi_n && lo_n) begin
      gates = 2'h2;
    end else if (hi_n && !lo_n) begin
      gates = 2'h1;
    end else begin
      gates = 2'h0;
    end
    return gates;
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // The two flops and the gate output register are the only delay on the commands: no glitch filter is
  // applied, so a pulse narrower than a clock may be missed entirely.
  logic [2:0] hi_meta;
  logic [2:0] hi_sync_n;
  logic [2:0] hi_prev_n;
  logic [2:0] lo_meta;
  logic [2:0] lo_sync_n;
  logic [2:0] lo_prev_n;
  logic       en_meta;
  logic       en_sync;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hi_meta   <= 3'h7;
      hi_sync_n <= 3'h7;
      hi_prev_n <= 3'h7;
      lo_meta   <= 3'h7;
      lo_sync_n <= 3'h7;
      lo_prev_n <= 3'h7;
    end else if (clk_en) begin
      hi_meta   <= link.high_side_cmd_n;
      hi_sync_n <= hi_meta;
      hi_prev_n <= hi_sync_n;
      lo_meta   <= link.low_side_cmd_n;
      lo_sync_n <= lo_meta;
      lo_prev_n <= lo_sync_n;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      en_meta <= 1'b0;
      en_sync <= 1'b0;
    end else if (clk_en) begin
      en_meta <= link.enable;
      en_sync <= en_meta;
    end
  end

  // --------------------------------------------------------------------------
  // Enable filter
  // --------------------------------------------------------------------------
  // An integrator with hysteresis: the filtered level only changes after the
  // count saturates, so noise shorter than the time constant is rejected.
  logic [8:0] en_count;
  logic       en_filt;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      en_count <= 9'h000;
    end else if (clk_en) begin
      if (en_sync && en_count != FILTER_MAX) begin
        en_count <= en_count + 9'h001;
      end else if (!en_sync && en_count != 9'h000) begin
        en_count <= en_count - 9'h001;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      en_filt <= 1'b0;
    end else if (clk_en) begin
      if (en_count == FILTER_MAX) begin
        en_filt <= 1'b1;
      end else if (en_count == 9'h000) begin
        en_filt <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Protection monitors
  // --------------------------------------------------------------------------
  gate_drive_pkg::prot_flags_t next_flags;
  logic [2:0]                  gate_under;
  logic [2:0]                  next_gate_under;

  always_comb begin
    next_flags.over_voltage = trip_rising(protection_flags.over_voltage, main_supply_mv,
                                          `OVP_TRIP_MV, `OVP_RELEASE_MV);
    next_flags.main_under   = trip_falling(protection_flags.main_under, main_supply_mv,
                                           `MAIN_UV_TRIP_MV, `MAIN_UV_RELEASE_MV);
    next_flags.logic_under  = trip_falling(protection_flags.logic_under, logic_supply_mv,
                                           `LOGIC_UV_TRIP_MV, `LOGIC_UV_RELEASE_MV);
    for (int i = 0; i < 3; i++) begin
      next_gate_under[i] = trip_falling(gate_under[i], gate_drive_supply_mv[i],
                                        `GATE_UV_TRIP_MV, `GATE_UV_RELEASE_MV);
    end
    next_flags.gate_under   = |next_gate_under;
    next_flags.thermal      = trip_rising(protection_flags.thermal, {8'h00, junction_temp_c},
                                          {8'h00, HOT_TRIP}, {8'h00, HOT_RELEASE});
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      protection_flags <= '0;
      gate_under       <= 3'h0;
    end else if (clk_en) begin
      protection_flags <= next_flags;
      gate_under       <= next_gate_under;
    end
  end

  // Only the boost stops under main undervoltage; the oscillator keeps going.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      charge_pump_boost_en <= 1'b0;
      oscillator_run       <= 1'b1;
    end else if (clk_en) begin
      charge_pump_boost_en <= ~next_flags.main_under;
      oscillator_run       <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Output blocking and rearm
  // --------------------------------------------------------------------------
  // Gate supply undervoltage is left out of the shutdown term on purpose.
  logic       shutdown;
  logic       block;
  logic [2:0] falling;
  logic [2:0] armed;
  logic [2:0] next_armed;
  logic [2:0] next_high;
  logic [2:0] next_low;
  logic [1:0] gates;

  assign shutdown = protection_flags.over_voltage | protection_flags.main_under |
                    protection_flags.logic_under | protection_flags.thermal;
  assign block    = ~en_filt | shutdown;
  assign falling  = (hi_prev_n & ~hi_sync_n) | (lo_prev_n & ~lo_sync_n);

  always_comb begin
    gates = 2'h0;
    for (int i = 0; i < 3; i++) begin
      if (block) begin
        next_armed[i] = 1'b0;
      end else if (falling[i]) begin
        next_armed[i] = 1'b1;
      end else begin
        next_armed[i] = armed[i];
      end
      gates        = decode_phase(hi_sync_n[i], lo_sync_n[i]);
      next_high[i] = next_armed[i] & ~block & gates[1];
      next_low[i]  = next_armed[i] & ~block & gates[0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      armed           <= 3'h0;
      high_gate_drive <= 3'h0;
      low_gate_drive  <= 3'h0;
    end else if (clk_en) begin
      armed           <= next_armed;
      high_gate_drive <= next_high;
      low_gate_drive  <= next_low;
    end
  end

  // --------------------------------------------------------------------------
  // Fault output
  // --------------------------------------------------------------------------
  // Open drain: the pin is only ever pulled low, and stays released while
  // the filtered enable is low whatever the monitors say.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      link.fault_out_n_out <= 1'b0;
      link.fault_out_n_oe  <= 1'b0;
    end else if (clk_en) begin
      link.fault_out_n_out <= 1'b0;
      link.fault_out_n_oe  <= en_filt & (|protection_flags);
    end
  end

endmodule

// ### sim/gate_drive_props.sv
// Concurrent checks on the gate drive link and the device outputs.
`timescale 1ns/1ps
`include "gate_drive_map.svh"
module gate_drive_props (
  input wire logic                        core_clk,
  input wire logic                        reset,
  input wire logic [2:0]                  high_side_cmd_n,
  input wire logic [2:0]                  low_side_cmd_n,
  input wire logic                        enable,
  input wire logic                        fault_out_n,
  input wire logic [2:0]                  high_gate_drive,
  input wire logic [2:0]                  low_gate_drive,
  input wire logic [15:0]                 main_supply_mv,
  input wire logic [7:0]                  junction_temp_c,
  input wire gate_drive_pkg::prot_flags_t protection_flags
);
  logic [8:0] low_run;
  logic [8:0] high_run;

  // ------------------------------------------------------------
  // Enable history, saturating at 300 cycles, well past the filter.
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      low_run  <= 9'h000;
      high_run <= 9'h000;
    end else begin
      low_run  <= enable ? 9'h000 : low_run + 9'(low_run != 9'h12C);
      high_run <= enable ? high_run + 9'(high_run != 9'h12C) : 9'h000;
    end
  end

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_no_shoot_through: assert property (
    (high_gate_drive & low_gate_drive) == 3'h0) else $error("both gates of a phase on");
  a_high_gate_cause: assert property (
    (high_gate_drive & ($past(high_side_cmd_n, 3) | ~$past(low_side_cmd_n, 3))) == 3'h0)
    else $error("high gate without its command");
  a_low_gate_cause: assert property (
    (low_gate_drive & ($past(low_side_cmd_n, 3) | ~$past(high_side_cmd_n, 3))) == 3'h0)
    else $error("low gate without its command");
  a_disabled_idle: assert property (low_run == 9'h12C |->
    (high_gate_drive | low_gate_drive) == 3'h0 && fault_out_n) else $error("disabled but active");
  a_hard_stop: assert property (
    (|{protection_flags[4:2], protection_flags[0]}) |=> (high_gate_drive | low_gate_drive) == 3'h0)
    else $error("gates on in shutdown");
  a_fault_raised: assert property (
    high_run == 9'h12C && protection_flags != 5'h00 |=> !fault_out_n) else $error("fault not low");
  a_fault_cleared: assert property (
    protection_flags == 5'h00 |=> fault_out_n) else $error("fault stuck low");
  a_overvoltage_trip: assert property (
    main_supply_mv >= `OVP_TRIP_MV |=> protection_flags.over_voltage) else $error("no overvoltage");
  a_thermal_trip: assert property (
    junction_temp_c >= `THERMAL_TRIP_C |=> protection_flags.thermal) else $error("no heat trip");
endmodule

// ### sim/tb.sv
// Self-checking bench: controller and gate drive device joined over the pin interface.
`timescale 1ns/1ps
`include "gate_drive_map.svh"
module tb;
  logic                        core_clk;
  logic                        reset;
  logic [7:0]                  reg_addr;
  logic [31:0]                 reg_wdata;
  logic                        reg_write;
  logic                        reg_read;
  logic [31:0]                 reg_rdata;
  logic [15:0]                 main_supply_mv;
  logic [15:0]                 logic_supply_mv;
  logic [2:0][15:0]            gate_drive_supply_mv;
  logic [7:0]                  junction_temp_c;
  logic [2:0]                  high_gate_drive;
  logic [2:0]                  low_gate_drive;
  logic [1:0]                  pump_osc;
  gate_drive_pkg::prot_flags_t protection_flags;
  int                          n_fail;
  int                          n_compared;
  int                          cycles;
  int                          tgt[3];
  int                          arm[3];
  logic [31:0]                 rd;
  logic [15:0]                 trip_v[5] = '{16'h6D60, 16'h17D4, 16'h0ED8, 16'h1BBC, 16'h00A5};
  logic [15:0]                 mid_v[5] = '{16'h6590, 16'h189C, 16'h0F3C, 16'h1C84, 16'h00A0};
  logic [15:0]                 rel_v[5] = '{16'h61A8, 16'h1964, 16'h0FA0, 16'h1D4C, 16'h009B};

  gate_drive_if link ();
  gate_drive_controller u_gate_drive_controller (.core_clk(core_clk), .reset(reset),
    .clk_en(1'b1), .link(link), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
  gate_drive_logic u_gate_drive_logic (.core_clk(core_clk), .reset(reset), .clk_en(1'b1),
    .link(link), .main_supply_mv(main_supply_mv), .logic_supply_mv(logic_supply_mv),
    .gate_drive_supply_mv(gate_drive_supply_mv), .junction_temp_c(junction_temp_c),
    .high_gate_drive(high_gate_drive), .low_gate_drive(low_gate_drive),
    .charge_pump_boost_en(pump_osc[1]), .oscillator_run(pump_osc[0]),
    .protection_flags(protection_flags));
  gate_drive_props u_gate_drive_props (.core_clk(core_clk), .reset(reset),
    .high_side_cmd_n(link.high_side_cmd_n), .low_side_cmd_n(link.low_side_cmd_n),
    .enable(link.enable), .fault_out_n(link.fault_out_n), .high_gate_drive(high_gate_drive),
    .low_gate_drive(low_gate_drive), .main_supply_mv(main_supply_mv),
    .junction_temp_c(junction_temp_c), .protection_flags(protection_flags));

  // ------------------------------------------------------------
  // Bus cycles, model and comparison
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %0t got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  // A phase only follows its command after a falling command edge rearms it.
  task automatic check_gates();
    logic [5:0] e = 6'h00;
    for (int i = 0; i < 3; i++) begin
      e[3 + i] = arm[i] == 1 && tgt[i] == 1;
      e[i]     = arm[i] == 1 && tgt[i] == 2;
    end
    chk({26'h0, high_gate_drive, low_gate_drive}, {26'h0, e});
  endtask
  task automatic drive(input int t0, input int t1, input int t2);
    int n[3] = '{t0, t1, t2};
    for (int i = 0; i < 3; i++) begin
      if ((n[i] == 1 || n[i] == 2) && n[i] != tgt[i]) begin
        arm[i] = 1;
      end
    end
    tgt = n;
    wr(`REG_TARGET, 32'(t0 + 4 * t1 + 16 * t2));
    repeat (200) @(posedge core_clk);
  endtask
  task automatic set_mon(input int p, input logic [15:0] v);
    case (p)
      0, 1: main_supply_mv <= v;
      2: logic_supply_mv <= v;
      3: gate_drive_supply_mv[1] <= v;
      default: junction_temp_c <= v[7:0];
    endcase
  endtask
  task automatic end_sim();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    {n_fail, n_compared, cycles} = '0;
    {reset, reg_addr, reg_wdata, reg_write, reg_read} = {1'b1, 42'h0};
    {main_supply_mv, logic_supply_mv, junction_temp_c} = {16'h36B0, 16'h1388, 8'h19};
    gate_drive_supply_mv = {3{16'h2EE0}};
    tgt = '{0, 0, 0};
    arm = '{1, 1, 1};
    rd = $urandom(32'h5c56);
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rdr(`REG_DEAD);
    chk(rd, {24'h0, `DEAD_RESET});
    wr(`REG_DEAD, 32'h64);
    rdr(`REG_DEAD);
    chk(rd, 32'h64);
    rdr(8'h40);
    chk(rd, 32'h0);
    chk({31'h0, link.fault_out_n}, 32'h1);
    wr(`REG_CTRL, 32'h1);
    for (int k = 0; k < 400 && rd[2:1] !== 2'h2; k++) begin
      repeat (10) @(posedge core_clk);
      rdr(`REG_STATUS);
    end
    chk(rd, 32'h4);
    for (int k = 0; k < 16; k++) begin
      drive($urandom % 4, $urandom % 4, $urandom % 4);
      check_gates();
    end
    drive(1, 2, 1);
    for (int p = 0; p < 5; p++) begin
      set_mon(p, trip_v[p]);
      repeat (5) @(posedge core_clk);
      if (p != 3) begin
        arm = '{0, 0, 0};
      end
      chk({31'h0, link.fault_out_n}, 32'h0);
      chk({30'h0, pump_osc}, {30'h0, p != 1, 1'b1});
      check_gates();
      set_mon(p, mid_v[p]);
      repeat (5) @(posedge core_clk);
      chk({31'h0, link.fault_out_n}, 32'h0);
      set_mon(p, rel_v[p]);
      repeat (5) @(posedge core_clk);
      chk({31'h0, link.fault_out_n}, 32'h1);
      check_gates();
      drive(0, 0, 0);
      drive(1, 2, 1);
      check_gates();
    end
    wr(`REG_CTRL, 32'h0);
    set_mon(3, trip_v[3]);
    arm = '{0, 0, 0};
    repeat (300) @(posedge core_clk);
    chk({31'h0, link.fault_out_n}, 32'h1);
    check_gates();
    end_sim();
  end
endmodule
